// ### hw/mgsi_top.v
// Functional notes
// - Input pins read the pad level at read time; writes do not affect them.
// - Output pins take software value, readable back, and driven on the pad.
// - After reset all pins are inputs with pull-down enabled.
// - Output pins drive both levels (push-pull).
// - Alternate-function pins take level and direction from internal logic.
// - Status indicator only on pin eight, only when enabled by configuration.
// - Indicator off while device off, steady on while not registered.
// - Registered idle: indicator one second on, two seconds off, repeated.
// - Connecting: same one second on, two seconds off pattern.
// - Power saving idle: indicator updates only on paging wake-up events.
// - Auxiliary serial and SPI share pads; at most one enabled at once.
// - Auxiliary serial drives transmit pad and samples receive pad.
`timescale 1ns/1ps
`include "mgsi_defs.vh"
module mgsi_top #(
  parameter [31:0] ON_CYC  = `MGSI_ON_CYC,
  parameter [31:0] OFF_CYC = `MGSI_OFF_CYC
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  // General pins
  input  wire [7:0]  gpio_i,
  output reg  [7:0]  gpio_o,
  output reg  [7:0]  gpio_oe_b_o,
  output reg  [7:0]  gpio_pd_en_o,
  // Alternate function sources
  input  wire [7:0]  alt_lvl_i,
  input  wire [7:0]  alt_oe_i,
  // Device network state and paging wake-up
  input  wire [2:0]  dev_state_i,
  input  wire        page_wake_i,
  // Auxiliary serial and SPI shared pads
  input  wire        aux_tx_i,
  output reg         aux_rx_o,
  input  wire        spi_mosi_i,
  output reg         spi_miso_o,
  output reg         shr_tx_pad_o,
  input  wire        shr_rx_pad_i
);
  reg  [7:0]  dir;
  reg  [7:0]  out_val;
  reg  [7:0]  alt;
  reg  [3:0]  cfg;
  reg  [7:0]  gpio_s1;
  reg  [7:0]  gpio_s2;
  reg         rx_s1;
  reg         rx_s2;
  reg         wake_s1;
  reg         wake_s2;
  reg         wake_q;
  reg         psm_led;
  reg         led;
  reg         next_led;
  reg  [7:0]  aw_addr;
  reg         aw_have;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_have;
  reg  [31:0] next_rdata;
  reg         next_rerr;
  wire [7:0]  next_pin;
  wire [7:0]  next_oe_b;
  wire        blink_led;
  wire        blink_on;
  wire        wr_go;
  wire        wake_rise;

  // Two-stage pad and event synchronisers
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gpio_s1 <= 8'h00;
      gpio_s2 <= 8'h00;
      rx_s1   <= 1'b0;
      rx_s2   <= 1'b0;
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      gpio_s1 <= gpio_i;
      gpio_s2 <= gpio_s1;
      rx_s1   <= shr_rx_pad_i;
      rx_s2   <= rx_s1;
      wake_s1 <= page_wake_i;
      wake_s2 <= wake_s1;
      wake_q  <= wake_s2;
    end
  end
  // Synced rising edge marks a wake-up
  assign wake_rise = wake_s2 && !wake_q;

  // Indicator blink timer
  assign blink_on = (dev_state_i == `MGSI_ST_IDLE) || (dev_state_i == `MGSI_ST_CONN);
  mgsi_blink #(
    .ON_CYC  (ON_CYC),
    .OFF_CYC (OFF_CYC)
  ) u_blink (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .blink_i   (blink_on),
    .led_o     (blink_led)
  );

  // Power-save indicator toggled on paging wake-ups
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      psm_led <= 1'b0;
    end else if (wake_rise) begin
      psm_led <= ~psm_led;
    end
  end

  // Indicator level per device state
  always @* begin
    case (dev_state_i)
      `MGSI_ST_OFF:    next_led = 1'b0;
      `MGSI_ST_NOTREG: next_led = 1'b1;
      `MGSI_ST_IDLE:   next_led = blink_led;
      `MGSI_ST_CONN:   next_led = blink_led;
      `MGSI_ST_PSM:    next_led = psm_led;
      default:         next_led = 1'b0;
    endcase
  end

  // Pin muxing per bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      reg         pin_v;
      reg         oe_b_v;
      // Indicator wins over alternate and plain use
      always @* begin
        if (gi == `MGSI_LED_PIN && cfg[`MGSI_CFG_LED_EN]) begin
          pin_v  = led;
          oe_b_v = 1'b0;
        end else if (alt[gi]) begin
          pin_v  = alt_lvl_i[gi];
          oe_b_v = ~alt_oe_i[gi];
        end else begin
          pin_v  = out_val[gi];
          oe_b_v = ~dir[gi];
        end
      end
      assign next_pin[gi]  = pin_v;
      assign next_oe_b[gi] = oe_b_v;
    end
  endgenerate

  // Pad outputs and shared serial/SPI pads
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      led          <= 1'b0;
      gpio_o       <= 8'h00;
      gpio_oe_b_o  <= 8'hff;
      gpio_pd_en_o <= 8'hff;
      shr_tx_pad_o <= 1'b0;
      aux_rx_o     <= 1'b0;
      spi_miso_o   <= 1'b0;
    end else begin
      led          <= next_led;
      gpio_o       <= next_pin;
      gpio_oe_b_o  <= next_oe_b;
      // Pull-down only while not driving, so idle pins read low
      gpio_pd_en_o <= next_oe_b;
      // Shared pads serve one port; idle low otherwise
      if (cfg[`MGSI_CFG_AUX_EN]) begin
        shr_tx_pad_o <= aux_tx_i;
        aux_rx_o     <= rx_s2;
        spi_miso_o   <= 1'b0;
      end else if (cfg[`MGSI_CFG_SPI_EN]) begin
        shr_tx_pad_o <= spi_mosi_i;
        aux_rx_o     <= 1'b0;
        spi_miso_o   <= rx_s2;
      end else begin
        shr_tx_pad_o <= 1'b0;
        aux_rx_o     <= 1'b0;
        spi_miso_o   <= 1'b0;
      end
    end
  end

  // AXI4-Lite write path
  // Answer once address and data are both held
  assign wr_go = aw_have && w_have && !s_axi_bvalid_o;
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_have         <= 1'b0;
      w_have          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= 2'b00;
      dir             <= `MGSI_DIR_RST;
      out_val         <= `MGSI_OUT_RST;
      alt             <= `MGSI_ALT_RST;
      cfg             <= `MGSI_CFG_RST;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have         <= 1'b1;
        aw_addr         <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have         <= 1'b1;
        w_data         <= s_axi_wdata_i;
        w_strb         <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        aw_have        <= 1'b0;
        w_have         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= 2'b00;
        case (aw_addr)
          `MGSI_OFF_DIR: if (w_strb[0]) dir <= w_data[7:0];
          `MGSI_OFF_OUT: if (w_strb[0]) out_val <= w_data[7:0];
          `MGSI_OFF_ALT: if (w_strb[0]) alt <= w_data[7:0];
          `MGSI_OFF_CFG: begin
            // Both shared ports at once would fight: refuse
            if (w_strb[0] && !(w_data[`MGSI_CFG_AUX_EN] && w_data[`MGSI_CFG_SPI_EN]))
              cfg <= w_data[3:0];
            else if (w_strb[0])
              s_axi_bresp_o <= 2'b10;
          end
          `MGSI_OFF_IN:   s_axi_bresp_o <= 2'b00;
          `MGSI_OFF_STAT: s_axi_bresp_o <= 2'b00;
          default:        s_axi_bresp_o <= 2'b10;
        endcase
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Read data decode
  always @* begin
    next_rerr = 1'b0;
    case (s_axi_araddr_i)
      `MGSI_OFF_DIR:  next_rdata = {24'h00_0000, dir};
      `MGSI_OFF_OUT:  next_rdata = {24'h00_0000, out_val};
      `MGSI_OFF_IN:   next_rdata = {24'h00_0000, gpio_s2};
      `MGSI_OFF_ALT:  next_rdata = {24'h00_0000, alt};
      `MGSI_OFF_CFG:  next_rdata = {28'h000_0000, cfg};
      `MGSI_OFF_STAT: next_rdata = {27'h000_0000, led, blink_on, dev_state_i};
      // Unmapped reads: error, zero data
      default: begin
        next_rdata = `MGSI_ERR_DATA;
        next_rerr  = 1'b1;
      end
    endcase
  end

  // AXI4-Lite read path
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= 2'b00;
    end else begin
      // One read in flight; data latched at the take
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= next_rdata;
        s_axi_rresp_o   <= next_rerr ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end
endmodule

// ### hw/mgsi_defs.vh
`ifndef MGSI_DEFS_VH
`define MGSI_DEFS_VH
// Register byte offsets
`define MGSI_OFF_DIR      8'h00
`define MGSI_OFF_OUT      8'h04
`define MGSI_OFF_IN       8'h08
`define MGSI_OFF_ALT      8'h0c
`define MGSI_OFF_CFG      8'h10
`define MGSI_OFF_STAT     8'h14
// Reset values
`define MGSI_DIR_RST      8'h00
`define MGSI_OUT_RST      8'h00
`define MGSI_ALT_RST      8'h00
`define MGSI_CFG_RST      4'h0
// Config fields
`define MGSI_CFG_LED_EN   0
`define MGSI_CFG_AUX_EN   1
`define MGSI_CFG_SPI_EN   2
// Indicator pin index
`define MGSI_LED_PIN      7
// Device states
`define MGSI_ST_OFF       3'h0
`define MGSI_ST_NOTREG    3'h1
`define MGSI_ST_IDLE      3'h2
`define MGSI_ST_PSM       3'h3
`define MGSI_ST_CONN      3'h4
// Blink timing
`define MGSI_CLK_HZ       100000000
`define MGSI_ON_MS        1000
`define MGSI_OFF_MS       2000
`define MGSI_ON_CYC       (`MGSI_CLK_HZ / 1000 * `MGSI_ON_MS)
`define MGSI_OFF_CYC      (`MGSI_CLK_HZ / 1000 * `MGSI_OFF_MS)
`define MGSI_ERR_DATA     32'h0000_0000
`endif

// ### hw/mgsi_blink.v
`timescale 1ns/1ps
`include "mgsi_defs.vh"
module mgsi_blink #(
  parameter [31:0] ON_CYC  = `MGSI_ON_CYC,
  parameter [31:0] OFF_CYC = `MGSI_OFF_CYC
) (
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_b_i,
  // Control
  input  wire       blink_i,
  output reg        led_o
);
  reg  [31:0] cnt;
  reg         blink_q;
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt     <= 32'h0000_0000;
      blink_q <= 1'b0;
      led_o   <= 1'b0;
    end else begin
      blink_q <= blink_i;
      if (blink_i && !blink_q) begin
        cnt   <= 32'h0000_0000;
        led_o <= 1'b1;
      end else if (blink_i) begin
        if (led_o && cnt >= ON_CYC - 32'h0000_0001) begin
          cnt   <= 32'h0000_0000;
          led_o <= 1'b0;
        end else if (!led_o && cnt >= OFF_CYC - 32'h0000_0001) begin
          cnt   <= 32'h0000_0000;
          led_o <= 1'b1;
        end else begin
          cnt <= cnt + 32'h0000_0001;
        end
      end else begin
        cnt   <= 32'h0000_0000;
        led_o <= 1'b0;
      end
    end
  end
endmodule

// ### dv/mgsi_pad_model.sv
`timescale 1ns/1ps
module mgsi_pad_model (
  // Pin state from the block
  input  wire [7:0] pin_val_i,
  input  wire [7:0] pin_oe_b_i,
  input  wire [7:0] pin_pd_i,
  // Host side drive
  input  wire [7:0] ext_en_i,
  input  wire [7:0] ext_val_i,
  // Resolved pad level
  output wire [7:0] pad_o
);
  // Driven pin shows its value, else host, else pull-down, else floats high
  assign pad_o = (~pin_oe_b_i & pin_val_i)
               | (pin_oe_b_i & ext_en_i & ext_val_i)
               | (pin_oe_b_i & ~ext_en_i & ~pin_pd_i);
endmodule

// ### dv/mgsi_top_properties.sv
`timescale 1ns/1ps
module mgsi_top_checker (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        rst_b_i,
  // Bus
  input wire        s_axi_awready_o,
  input wire        s_axi_wready_o,
  input wire [1:0]  s_axi_bresp_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0]  s_axi_rresp_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  // Pins and shared pads
  input wire [7:0]  gpio_oe_b_o,
  input wire [7:0]  gpio_pd_en_o,
  input wire        aux_rx_o,
  input wire        spi_miso_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  pull_follow_a: assert property (gpio_pd_en_o == gpio_oe_b_o)
    else $error("pull-down not tied to input mode");
  port_excl_a: assert property (!(aux_rx_o && spi_miso_o))
    else $error("both shared ports active");
  read_lat_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  read_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken while busy");
  err_zero_a: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2 |->
    s_axi_rdata_o == 32'h0000_0000)
    else $error("error read data not zero");
  wr_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response not held");
  wr_busy_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while busy");
endmodule
bind mgsi_top mgsi_top_checker u_chk (.sys_clk_i, .rst_b_i, .s_axi_awready_o, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .gpio_oe_b_o,
  .gpio_pd_en_o, .aux_rx_o, .spi_miso_o);

// ### dv/mgsi_top_tb.sv
`timescale 1ns/1ps
module mgsi_top_tb;
  logic        sys_clk_i = 0, rst_b_i = 0, page_wake_i = 0, aux_tx_i = 0;
  logic        spi_mosi_i = 0, shr_rx_pad_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
  logic        s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0, v, lazy = 0;
  logic [7:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0, alt_lvl_i = 0, alt_oe_i = 0;
  logic [7:0]  ext_en = 0, ext_val = 0;
  logic [31:0] s_axi_wdata_i = 0;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic [2:0]  dev_state_i = 0;
  wire  [7:0]  gpio_i, gpio_o, gpio_oe_b_o, gpio_pd_en_o;
  wire  [31:0] s_axi_rdata_o;
  wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  wire         s_axi_rvalid_o, aux_rx_o, spi_miso_o, shr_tx_pad_o;
  int          mismatches = 0, samples_checked = 0, cyc = 0, hi;
  mgsi_top #(.ON_CYC(32'h0000_000a), .OFF_CYC(32'h0000_0014)) uut (.sys_clk_i, .rst_b_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .gpio_i, .gpio_o, .gpio_oe_b_o, .gpio_pd_en_o,
    .alt_lvl_i, .alt_oe_i, .dev_state_i, .page_wake_i, .aux_tx_i, .aux_rx_o, .spi_mosi_i,
    .spi_miso_o, .shr_tx_pad_o, .shr_rx_pad_i);
  mgsi_pad_model pads (.pin_val_i(gpio_o), .pin_oe_b_i(gpio_oe_b_o), .pin_pd_i(gpio_pd_en_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(gpio_i));
  initial forever #5 sys_clk_i = ~sys_clk_i;
  task automatic finish_test;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      finish_test;
    end
  end
  task automatic chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Write and compare the response code
  task automatic wchk(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge sys_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= !lazy;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o && !s_axi_bready_i) s_axi_bready_i <= 1'b1;
    end while (!(s_axi_bvalid_o && s_axi_bready_i));
    chk(s_axi_bresp_o, er);
    s_axi_bready_i <= 1'b0;
  endtask
  // Read and compare data and response code
  task automatic rchk(input [7:0] a, input [31:0] ed, input [1:0] er);
    @(posedge sys_clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= !lazy;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o && !s_axi_rready_i) s_axi_rready_i <= 1'b1;
    end while (!(s_axi_rvalid_o && s_axi_rready_i));
    chk(s_axi_rdata_o, ed);
    chk(s_axi_rresp_o, er);
    s_axi_rready_i <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    tick(1);
    chk(gpio_oe_b_o, 8'hff);
    rchk(8'h00, 32'h0000_0000, 2'h0);
    rchk(8'h08, 32'h0000_0000, 2'h0);
    ext_en  <= 8'hff;
    ext_val <= 8'ha5;
    wchk(8'h08, 32'h0000_0000, 2'h0);
    tick(4);
    rchk(8'h08, 32'h0000_00a5, 2'h0);
    lazy = 1'b1;
    wchk(8'h04, 32'h0000_003c, 2'h0);
    wchk(8'h00, 32'h0000_000f, 2'h0);
    tick(4);
    chk(gpio_pd_en_o, 8'hf0);
    rchk(8'h04, 32'h0000_003c, 2'h0);
    lazy = 1'b0;
    rchk(8'h08, 32'h0000_00ac, 2'h0);
    wchk(8'h0c, 32'h0000_0001, 2'h0);
    alt_oe_i  <= 8'h01;
    alt_lvl_i <= 8'h01;
    tick(4);
    chk({gpio_oe_b_o[0], gpio_o[0]}, 2'h1);
    @(posedge sys_clk_i) alt_oe_i <= 8'h00;
    tick(4);
    chk(gpio_oe_b_o, 8'hf1);
    rchk(8'h20, 32'h0000_0000, 2'h2);
    wchk(8'h10, 32'h0000_0006, 2'h2);
    rchk(8'h10, 32'h0000_0000, 2'h0);
    wchk(8'h10, 32'h0000_0002, 2'h0);
    aux_tx_i     <= 1'b1;
    shr_rx_pad_i <= 1'b1;
    tick(5);
    chk({shr_tx_pad_o, aux_rx_o, spi_miso_o}, 3'h6);
    wchk(8'h10, 32'h0000_0004, 2'h0);
    tick(5);
    chk({shr_tx_pad_o, aux_rx_o, spi_miso_o}, 3'h1);
    chk(gpio_oe_b_o[7], 1'b1);
    wchk(8'h10, 32'h0000_0001, 2'h0);
    tick(4);
    chk({gpio_oe_b_o[7], gpio_o[7]}, 2'h0);
    @(posedge sys_clk_i) dev_state_i <= 3'h1;
    tick(4);
    chk(gpio_o[7], 1'b1);
    for (int s = 2; s <= 4; s += 2) begin
      @(posedge sys_clk_i) dev_state_i <= 3'h0;
      tick(4);
      @(posedge sys_clk_i) dev_state_i <= s[2:0];
      tick(4);
      chk(gpio_o[7], 1'b1);
      hi = 0;
      repeat (30) begin
        tick(1);
        hi += gpio_o[7];
      end
      chk(hi, 10);
    end
    @(posedge sys_clk_i) dev_state_i <= 3'h3;
    tick(4);
    v = gpio_o[7];
    tick(20);
    chk(gpio_o[7], v);
    @(posedge sys_clk_i) page_wake_i <= 1'b1;
    tick(6);
    chk(gpio_o[7], !v);
    finish_test;
  end
endmodule
